// File: hw/fcp_pkg.sv
/*
 * fcp_pkg: constants and types of the flash command and protection front end.
 * Assumes: registers sit on a 32-bit APB bus, one register per aligned word.
 */
package fcp_pkg;

	// register indices; the byte address is four times the index
	localparam logic [11:0] FCP_CMD_IDX   = 12'hFF8;
	localparam logic [11:0] FCP_PAGE_IDX  = 12'hFF9;
	localparam logic [11:0] FCP_FREQ_IDX  = 12'hFFA;
	localparam logic [11:0] FCP_OPT_IDX   = 12'hFFB;
	localparam int          FCP_ADDR_W    = 14;

	// command bytes
	localparam logic [7:0]  FCP_CMD_RESET   = 8'h00;
	localparam logic [7:0]  FCP_CMD_UNLOCK1 = 8'h73;
	localparam logic [7:0]  FCP_CMD_UNLOCK2 = 8'h8C;
	localparam logic [7:0]  FCP_CMD_PAGE_ER = 8'h95;
	localparam logic [7:0]  FCP_CMD_MASS_ER = 8'h63;
	localparam logic [7:0]  FCP_CMD_PROT_SEL = 8'h5E;

	// reset values
	localparam logic [7:0]  FCP_CMD_RST   = 8'h00;
	localparam logic [7:0]  FCP_PAGE_RST  = 8'h00;
	localparam logic [7:0]  FCP_PROT_RST  = 8'h00;
	localparam logic [15:0] FCP_FREQ_RST  = 16'h0000;
	localparam logic [7:0]  FCP_OPT_RST   = 8'h00;

	// field positions
	localparam int FCP_PAGE_INFO_BIT  = 7;
	localparam int FCP_OPT_WP_BIT     = 0;
	localparam int FCP_STAT_REFUSED   = 7;
	localparam int FCP_STAT_PROT_SEL  = 6;
	localparam int FCP_SECTOR_MSB     = 6;
	localparam int FCP_SECTOR_LSB     = 4;

	// state codes shown in the status register, bits [2:0]
	localparam logic [2:0]  FCP_CODE_LOCKED   = 3'h0;
	localparam logic [2:0]  FCP_CODE_FIRST    = 3'h1;
	localparam logic [2:0]  FCP_CODE_SECOND   = 3'h2;
	localparam logic [2:0]  FCP_CODE_UNLOCKED = 3'h3;
	localparam logic [2:0]  FCP_CODE_BUSY     = 3'h4;

	typedef enum logic [4:0] {
		FCP_ST_LOCKED   = 5'b00001,
		FCP_ST_FIRST    = 5'b00010,
		FCP_ST_SECOND   = 5'b00100,
		FCP_ST_UNLOCKED = 5'b01000,
		FCP_ST_BUSY     = 5'b10000
	} fcp_state_type;

	// erase request towards the flash array
	typedef struct packed {
		logic       mass;
		logic       info_area;
		logic [6:0] page;
	} fcp_erase_type;

endpackage

// File: hw/fcp_ctrl.sv
/*
 * fcp_ctrl: flash command decoder, unlock sequencer, sector protection and
 * write-permit gating, reached over APB.
 * Assumes: the flash array is on clk, takes a one-cycle erase start pulse with
 * its request and answers with a one-cycle erase_done pulse; the debug unit
 * gives a one-cycle mass erase pulse on clk.
 */
// Behaviour
// - command 73H is unlock step one, 8CH must follow as step two.
// - unlocked and 95H written starts erase of the selected page.
// - unlocked and 63H written starts erase of the whole array when no sector is protected.
// - command 5EH routes page-select address to the sector protect register.
// - write-permit bit 0 low refuses programming, page and mass erase from software.
// - write-permit bit high allows programming everywhere and page erase only in unprotected sectors.
// - debug unit mass erase proceeds even with software writes disabled.
// - writes at FF8H hit the command register, reads return status.
// - page-select register at FF9H, read/write, reset zero, info bit and page.
// - any out-of-order command write relocks the controller; a page write relocks after either unlock step except a same-page rewrite, not once unlocked.
// - protect register bits only set; cleared only by reset.
`timescale 1ns/1ns
`default_nettype none

module fcp_ctrl
	import fcp_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [FCP_ADDR_W-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  debug_mass_erase,
	input  wire logic                  erase_done,
	output logic                       erase_start,
	output fcp_erase_type              erase_req,
	output logic                       program_enable,
	output logic      [7:0]            sector_protect,
	output logic      [15:0]           clock_khz_value
);

	function automatic logic hit(input logic [FCP_ADDR_W-1:0] a, input logic [11:0] idx);
		hit = (a == {idx, 2'b00});
	endfunction

	fcp_state_type state_r;
	fcp_state_type state_nxt;
	logic [7:0]    cmd_r;
	logic [7:0]    page_r;
	logic [7:0]    prot_r;
	logic [15:0]   freq_r;
	logic [7:0]    opt_r;
	logic          refused_r;
	logic [31:0]   prdata_r;
	logic          erase_start_r;
	fcp_erase_type erase_req_r;

	// bus decode
	wire logic       acc       = psel & penable;
	wire logic       setup     = psel & ~penable;
	wire logic       sel_cmd   = hit(paddr, FCP_CMD_IDX);
	wire logic       sel_page  = hit(paddr, FCP_PAGE_IDX);
	wire logic       sel_freq  = hit(paddr, FCP_FREQ_IDX);
	wire logic       sel_opt   = hit(paddr, FCP_OPT_IDX);
	wire logic       mapped    = sel_cmd | sel_page | sel_freq | sel_opt;
	wire logic       wr        = acc & pwrite & mapped;
	wire logic       wr_cmd    = wr & sel_cmd & pstrb[0];
	wire logic       wr_page   = wr & sel_page & pstrb[0];
	wire logic [7:0] wbyte     = pwdata[7:0];

	// protect select follows the last command byte held in the command register
	wire logic       prot_sel  = (cmd_r == FCP_CMD_PROT_SEL);
	// page address reaches protect register while selected
	wire logic       wr_prot   = wr_page & prot_sel;
	wire logic       wr_pnum   = wr_page & ~prot_sel;

	wire logic       permit    = opt_r[FCP_OPT_WP_BIT];
	wire logic [2:0] sector    = page_r[FCP_SECTOR_MSB:FCP_SECTOR_LSB];
	wire logic       page_prot = prot_r[sector];
	wire logic       is_busy   = (state_r == FCP_ST_BUSY);

	wire logic       cmd_page  = wr_cmd & (wbyte == FCP_CMD_PAGE_ER) & (state_r == FCP_ST_UNLOCKED);
	wire logic       cmd_mass  = wr_cmd & (wbyte == FCP_CMD_MASS_ER) & (state_r == FCP_ST_UNLOCKED);
	wire logic       go_page   = cmd_page & permit & ~page_prot;
	wire logic       go_mass   = cmd_mass & permit & (prot_r == FCP_PROT_RST);
	// debug mass erase ignores the write-permit bit
	wire logic       go_debug  = debug_mass_erase & ~is_busy & ~go_page & ~go_mass;
	wire logic       refuse    = (cmd_page & ~go_page) | (cmd_mass & ~go_mass);

	logic [2:0] state_code;
	always_comb begin
		case (state_r)
			FCP_ST_LOCKED:   state_code = FCP_CODE_LOCKED;
			FCP_ST_FIRST:    state_code = FCP_CODE_FIRST;
			FCP_ST_SECOND:   state_code = FCP_CODE_SECOND;
			FCP_ST_UNLOCKED: state_code = FCP_CODE_UNLOCKED;
			FCP_ST_BUSY:     state_code = FCP_CODE_BUSY;
			default:         state_code = FCP_CODE_LOCKED;
		endcase
	end

	wire logic [7:0] status = {refused_r, prot_sel, 3'h0, state_code};

	// one address, write goes to command, read returns status
	wire logic [7:0] page_view = prot_sel ? prot_r : page_r;
	wire logic [31:0] rd_mux = sel_cmd  ? {24'h000000, status} :
	                           sel_page ? {24'h000000, page_view} :
	                           sel_freq ? {16'h0000, freq_r} :
	                           sel_opt  ? {24'h000000, opt_r} : 32'h00000000;

	// unlock sequencer
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			FCP_ST_LOCKED: begin
				if (wr_cmd && wbyte == FCP_CMD_UNLOCK1) begin
					state_nxt = FCP_ST_FIRST;
				end
			end
			FCP_ST_FIRST: begin
				// any command or page write but the second byte relocks
				if (wr_cmd && wbyte == FCP_CMD_UNLOCK2) begin
					state_nxt = FCP_ST_SECOND;
				end else if (wr_cmd || wr_page) begin
					state_nxt = FCP_ST_LOCKED;
				end
			end
			FCP_ST_SECOND: begin
				// only a rewrite of the same page completes the unlock
				if (wr_pnum && wbyte == page_r) begin
					state_nxt = FCP_ST_UNLOCKED;
				end else if (wr_cmd || wr_page) begin
					state_nxt = FCP_ST_LOCKED;
				end
			end
			FCP_ST_UNLOCKED: begin
				if (go_page || go_mass) begin
					state_nxt = FCP_ST_BUSY;
				end else if (wr_cmd || wr_prot) begin
					state_nxt = FCP_ST_LOCKED;
				end
			end
			FCP_ST_BUSY: begin
				if (erase_done) begin
					state_nxt = FCP_ST_LOCKED;
				end
			end
			default: state_nxt = FCP_ST_LOCKED;
		endcase
		if (go_debug) begin
			state_nxt = FCP_ST_BUSY;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= FCP_ST_LOCKED;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cmd_r <= FCP_CMD_RST;
		end else if (wr_cmd) begin
			cmd_r <= wbyte;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			page_r <= FCP_PAGE_RST;
		end else if (wr_pnum) begin
			page_r <= wbyte;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			prot_r <= FCP_PROT_RST;
		end else if (wr_prot) begin
			prot_r <= prot_r | wbyte;
		end
	end

	// kilohertz value, byte lanes 0 and 1
	always_ff @(posedge clk) begin
		if (reset) begin
			freq_r <= FCP_FREQ_RST;
		end else if (wr && sel_freq) begin
			if (pstrb[0]) begin
				freq_r[7:0] <= pwdata[7:0];
			end
			if (pstrb[1]) begin
				freq_r[15:8] <= pwdata[15:8];
			end
		end
	end

	// option copy, reserved bit 1 held at zero
	always_ff @(posedge clk) begin
		if (reset) begin
			opt_r <= FCP_OPT_RST;
		end else if (wr && sel_opt && pstrb[0]) begin
			opt_r <= {6'h00, 1'b0, wbyte[FCP_OPT_WP_BIT]};
		end
	end

	// refused flag, a new refusal wins over the clearing command write
	always_ff @(posedge clk) begin
		if (reset) begin
			refused_r <= 1'b0;
		end else if (refuse) begin
			refused_r <= 1'b1;
		end else if (wr_cmd) begin
			refused_r <= 1'b0;
		end
	end

	// erase launch towards the array
	always_ff @(posedge clk) begin
		if (reset) begin
			erase_start_r <= 1'b0;
			erase_req_r   <= '0;
		end else begin
			erase_start_r <= go_page | go_mass | go_debug;
			if (go_page || go_mass || go_debug) begin
				erase_req_r.mass      <= ~go_page;
				erase_req_r.info_area <= page_r[FCP_PAGE_INFO_BIT];
				erase_req_r.page      <= page_r[6:0];
			end
		end
	end

	// read data is captured in the setup cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			prdata_r <= 32'h00000000;
		end else if (setup && !pwrite) begin
			prdata_r <= rd_mux;
		end
	end

	assign pready          = 1'b1;
	assign pslverr         = acc & ~mapped;
	assign prdata          = prdata_r;
	assign erase_start     = erase_start_r;
	assign erase_req       = erase_req_r;
	// byte programming allowed only when unlocked and permitted
	assign program_enable  = (state_r == FCP_ST_UNLOCKED) & permit;
	assign sector_protect  = prot_r;
	assign clock_khz_value = freq_r;

endmodule

`default_nettype wire

// File: tb/fcp_ctrl_monitor.sv
/* fcp_ctrl_monitor: port-level checks of the flash command front end.
 * Assumes: bound into fcp_ctrl, one clock, synchronous active-high reset. */
`timescale 1ns/1ns
`default_nettype none
module fcp_ctrl_monitor
	import fcp_pkg::*;
(
	input wire logic                  clk,
	input wire logic                  reset,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [FCP_ADDR_W-1:0] paddr,
	input wire logic [31:0]           pwdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire logic                  debug_mass_erase,
	input wire logic                  erase_done,
	input wire logic                  erase_start,
	input wire fcp_erase_type         erase_req,
	input wire logic                  program_enable,
	input wire logic [7:0]            sector_protect,
	input wire logic [15:0]           clock_khz_value
);
	logic busy_r;
	wire  cmd_w = psel && penable && pwrite && paddr == {FCP_CMD_IDX, 2'h0};
	wire  ers_w = cmd_w && (pwdata[7:0] == FCP_CMD_PAGE_ER || pwdata[7:0] == FCP_CMD_MASS_ER);
	wire  map_w = paddr[13:4] == 10'h3FE && paddr[1:0] == 2'h0;

	always_ff @(posedge clk) begin
		if (reset || erase_done)
			busy_r <= 1'h0;
		else if (erase_start)
			busy_r <= 1'h1;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_cmd(logic [7:0] v);
		cmd_w && pwdata[7:0] == v;
	endsequence

	chk_ready_high: assert property (pready)
		else $error("pready low");
	chk_slverr_map: assert property (psel && penable |-> pslverr == !map_w)
		else $error("pslverr wrong for address");
	chk_start_cause: assert property (erase_start |-> $past(ers_w) || $past(debug_mass_erase))
		else $error("erase start without request");
	chk_start_pulse: assert property (erase_start |=> !erase_start)
		else $error("erase start longer than one cycle");
	chk_page_go: assert property (s_cmd(FCP_CMD_PAGE_ER) ##0 (program_enable && sector_protect == 8'h00) |=> erase_start && !erase_req.mass)
		else $error("page erase not started");
	chk_mass_go: assert property (s_cmd(FCP_CMD_MASS_ER) ##0 (program_enable && sector_protect == 8'h00) |=> erase_start && erase_req.mass)
		else $error("mass erase not started");
	chk_lock_refuse: assert property (s_cmd(FCP_CMD_PAGE_ER) ##0 (!program_enable && !debug_mass_erase) |=> !erase_start)
		else $error("erase started while not permitted");
	chk_debug_mass: assert property (debug_mass_erase && !busy_r && !erase_start && !ers_w |=> erase_start && erase_req.mass)
		else $error("debug mass erase ignored");
	chk_prot_sticky: assert property (1'h1 |=> (sector_protect & $past(sector_protect)) == $past(sector_protect))
		else $error("protect bit cleared");
	chk_reset_clear: assert property ($fell(reset) |-> sector_protect == 8'h00 && clock_khz_value == 16'h0000 && !erase_start)
		else $error("register not cleared by reset");
endmodule
bind fcp_ctrl fcp_ctrl_monitor u_mon (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
	.debug_mass_erase, .erase_done, .erase_start, .erase_req, .program_enable, .sector_protect, .clock_khz_value);
`default_nettype wire

// File: tb/tb_fcp_ctrl.sv
/* tb_fcp_ctrl: self-checking bench for the flash command front end.
 * Assumes: fcp_ctrl answers APB with zero wait states. */
`timescale 1ns/1ns
`default_nettype none
module tb_fcp_ctrl import fcp_pkg::*;;
	localparam logic [13:0] CA = {FCP_CMD_IDX, 2'h0};
	localparam logic [13:0] PA = {FCP_PAGE_IDX, 2'h0};
	localparam logic [13:0] KA = {FCP_FREQ_IDX, 2'h0};
	localparam logic [13:0] OA = {FCP_OPT_IDX, 2'h0};
	logic          clk, reset, psel, penable, pwrite, pready, pslverr, err;
	logic          debug_mass_erase, erase_done, erase_start, program_enable;
	logic [13:0]   paddr;
	logic [31:0]   pwdata, prdata, rdv;
	logic [3:0]    pstrb;
	logic [7:0]    sector_protect;
	logic [15:0]   clock_khz_value;
	fcp_erase_type erase_req;
	int            bad_count, checks_done;
	int            start_count;

	fcp_ctrl u_dut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
		.debug_mass_erase, .erase_done, .erase_start, .erase_req, .program_enable, .sector_protect, .clock_khz_value);

	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	// counts erase start pulses seen on the array side
	always @(posedge clk) begin
		if (erase_start) begin
			start_count <= start_count + 1;
		end
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	// one APB transfer, held until pready is sampled high, then released
	task automatic xf(input logic w, input logic [13:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		@(posedge clk);
		while (pready !== 1'h1) @(posedge clk);
		rdv = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [13:0] a, input logic [7:0] d);
		xf(1'h1, a, {24'h0, d});
	endtask

	task automatic st(input logic [7:0] e, input logic [7:0] m);
		xf(1'h0, CA, 32'h0);
		ck("status", {24'h0, e}, rdv & {24'h0, m});
	endtask

	task automatic pls(input logic d);
		debug_mass_erase <= d;
		erase_done <= !d;
		@(posedge clk);
		debug_mass_erase <= 1'h0;
		erase_done <= 1'h0;
		@(posedge clk);
	endtask

	task automatic unlock(input logic [7:0] p);
		wr(CA, 8'h00);
		wr(PA, p);
		wr(CA, FCP_CMD_UNLOCK1);
		wr(CA, FCP_CMD_UNLOCK2);
		wr(PA, p);
	endtask

	task automatic t_regs;
		st(8'h00, 8'hFF);
		xf(1'h0, PA, 32'h0);
		ck("page", 32'h0, rdv);
		xf(1'h0, 14'h0100, 32'h0);
		ck("slverr", 32'h1, {31'h0, err});
		ck("unmapped", 32'h0, rdv);
		xf(1'h1, KA, 32'h1234);
		wr(PA, 8'hA5);
		xf(1'h0, PA, 32'h0);
		ck("page", 32'hA5, rdv);
		ck("khz", 32'h1234, {16'h0, clock_khz_value});
	endtask

	task automatic t_unlock_page;
		wr(OA, 8'h01);
		wr(CA, 8'h00);
		wr(PA, 8'hA5);
		wr(CA, FCP_CMD_UNLOCK1);
		st(8'h01, 8'h07);
		wr(CA, FCP_CMD_UNLOCK2);
		st(8'h02, 8'h07);
		wr(PA, 8'hA5);
		st(8'h03, 8'h07);
		ck("prog_en", 32'h1, {31'h0, program_enable});
		wr(CA, FCP_CMD_PAGE_ER);
		st(8'h04, 8'h07);
		ck("starts", 32'h1, start_count);
		ck("erase_req", 32'h0A5, {23'h0, erase_req});
		pls(1'h0);
		st(8'h00, 8'h07);
	endtask

	task automatic t_mass;
		unlock(8'h10);
		wr(CA, FCP_CMD_MASS_ER);
		st(8'h04, 8'h07);
		ck("starts", 32'h2, start_count);
		ck("mass", 32'h1, {31'h0, erase_req.mass});
		pls(1'h0);
	endtask

	task automatic t_order;
		wr(CA, 8'h00);
		wr(PA, 8'h05);
		wr(CA, FCP_CMD_UNLOCK1);
		wr(CA, FCP_CMD_PAGE_ER);
		st(8'h00, 8'h07);
		wr(CA, 8'h00);
		wr(PA, 8'h05);
		wr(CA, FCP_CMD_UNLOCK1);
		wr(CA, FCP_CMD_UNLOCK2);
		wr(PA, 8'h06);
		st(8'h00, 8'h07);
		ck("starts", 32'h2, start_count);
	endtask

	task automatic t_permit;
		wr(OA, 8'h00);
		unlock(8'h05);
		ck("prog_en", 32'h0, {31'h0, program_enable});
		wr(CA, FCP_CMD_PAGE_ER);
		st(8'h80, 8'hFF);
		ck("starts", 32'h2, start_count);
		pls(1'h1);
		st(8'h04, 8'h07);
		ck("starts", 32'h3, start_count);
		ck("mass", 32'h1, {31'h0, erase_req.mass});
		pls(1'h0);
	endtask

	task automatic t_protect;
		wr(CA, FCP_CMD_PROT_SEL);
		wr(PA, 8'h02);
		wr(PA, 8'h01);
		st(8'h40, 8'h40);
		xf(1'h0, PA, 32'h0);
		ck("protect", 32'h03, rdv);
		ck("sector", 32'h03, {24'h0, sector_protect});
		wr(OA, 8'h01);
		unlock(8'h15);
		wr(CA, FCP_CMD_PAGE_ER);
		st(8'h80, 8'hFF);
		ck("starts", 32'h3, start_count);
	endtask

	task automatic t_reset;
		reset <= 1'h1;
		repeat (2) @(posedge clk);
		reset <= 1'h0;
		st(8'h00, 8'hFF);
		ck("sector", 32'h0, {24'h0, sector_protect});
		ck("khz", 32'h0, {16'h0, clock_khz_value});
		xf(1'h0, PA, 32'h0);
		ck("page", 32'h0, rdv);
		ck("starts", 32'h3, start_count);
	endtask

	initial begin
		{psel, penable, pwrite, debug_mass_erase, erase_done} = 5'h00;
		paddr = 14'h0000;
		pwdata = 32'h0;
		pstrb = 4'hF;
		reset = 1'h1;
		repeat (6) @(posedge clk);
		reset <= 1'h0;
		t_regs();
		t_unlock_page();
		t_mass();
		t_order();
		t_permit();
		t_protect();
		t_reset();
		end_sim();
	end

	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		end_sim();
	end
endmodule
`default_nettype wire
